// ==== hdl/tpm_regs.svh ====
// Register offsets, field positions and reset values of the test probe multiplexer.
// Assumes a classic Wishbone slave with 32-bit data and byte addressing.
`ifndef TPM_REGS_SVH
`define TPM_REGS_SVH

`define TPM_CONTROL_OFFSET 8'h00
`define TPM_CONTROL_RESET 8'h00
`define TPM_ANALOG_EN_BIT 7
`define TPM_DIGITAL_EN_BIT 6
`define TPM_UNUSED_BIT 5
`define TPM_SELECT_MSB 4
`define TPM_SELECT_LSB 0
`define TPM_WRITE_MASK 8'hDF

`endif

// ==== hdl/tpm_pkg.sv ====
// Types shared by the test probe multiplexer.
// Assumes nothing of its surroundings.
package tpm_pkg;

  typedef enum logic [2:0] {
    TPM_PIN_NORMAL = 3'b001,
    TPM_PIN_ANALOG = 3'b010,
    TPM_PIN_DIGITAL = 3'b100
  } tpm_pin_mode_type;

  typedef struct packed {
    logic [7:0] control;
    logic ack;
    logic [31:0] rdata;
    logic [23:0] digital_sync_mid;
    logic [23:0] digital_sync;
    logic probe_level;
    logic probe_oe;
    logic analog_connect;
    logic [4:0] analog_channel;
    tpm_pin_mode_type mode;
  } tpm_state_type;

endpackage

// ==== hdl/tpm_test_probe_mux.sv ====
// Test probe multiplexer: routes one internal analog or digital signal onto the probe pin.
// Assumes a classic Wishbone master on clk_i; internal signals arrive asynchronously.
// Overview of operation
// - Analog enable bit 7 connects the analog multiplexer output through the buffer to the probe pin.
// - While analog probing, the adc_control_zero channel select field picks the analog signal shown.
// - Digital enable bit 6 drives the digital multiplexer output onto the probe pin.
// - Select field bits 4 to 0 choose which internal digital signal the digital multiplexer outputs.
// - Codes 00000, 00001 and 00010 give the half-period signal, system clock and current sample signal.
// - Codes 00011 to 00111 give the output over/undervoltage, input lockout and overcurrent comparators.
// - Codes 01000 to 01101 give drive, timer, PWM, clock select and emulation signals; 01111 gives blanking.
// - Codes 10000 to 10101 give the second signal group; 10111 gives the auto-zero signal ORed with blanking.
// - With both enables set, the digital multiplexer output has priority on the probe pin.
// - With both enables clear, the pin keeps its normal port function and neither multiplexer drives it.
// - Bit 5 ignores writes and always reads as zero.
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "tpm_regs.svh"

module tpm_test_probe_mux (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [4:0] analog_channel_select_i,
  input wire logic [23:0] digital_signals_i,
  output logic probe_pin_o,
  output logic probe_pin_oe_o,
  output logic analog_connect_o,
  output logic [4:0] analog_channel_o,
  output logic [7:0] test_probe_control_o
);

  tpm_pkg::tpm_state_type s_q;
  tpm_pkg::tpm_state_type s_d;

  // Digital source lines, index = bit of digital_signals_i:
  // 0 half period, 1 system clock, 2 current sample, 3 output overvoltage, 4 output undervoltage,
  // 5 input overvoltage lockout, 6 input undervoltage lockout, 7 overcurrent, 8 high-side on,
  // 9 low-side on before delay, 10 timer2_period_match, 11 PWM output, 12 clock select,
  // 13 diode_emulation comparator, 14 diode_emulation blanking, 15 PWM comparator,
  // 16 switching_frequency_signal, 17 auto-zero time.
  function automatic logic digital_pick(input logic [4:0] sel, input logic [23:0] sig);
    logic r;
    r = 1'b0;
    case (sel)
      5'h00: r = sig[0];
      5'h01: r = sig[1];
      5'h02: r = sig[2];
      5'h03: r = sig[3];
      5'h04: r = sig[4];
      5'h05: r = sig[5];
      5'h06: r = sig[6];
      5'h07: r = sig[7];
      5'h08: r = sig[8];
      5'h09: r = sig[9];
      5'h0A: r = sig[10];
      5'h0B: r = sig[11];
      5'h0C: r = sig[12];
      5'h0D: r = sig[13];
      5'h0F: r = sig[14];
      5'h10: r = sig[15];
      5'h11: r = sig[16];
      5'h12: r = sig[10];
      5'h13: r = sig[11];
      5'h14: r = sig[12];
      5'h15: r = sig[13];
      // Doubly listed code: blanking time ORed with auto-zero time
      5'h17: r = sig[14] | sig[17];
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic access;
  logic hit;

  always_comb begin
    s_d = s_q;
    access = wb_cyc_i && wb_stb_i && !s_q.ack;
    hit = (wb_adr_i == `TPM_CONTROL_OFFSET);
    s_d.ack = access;
    s_d.rdata = 32'h0000_0000;
    if (access && hit && !wb_we_i) begin
      s_d.rdata = {24'h00_0000, s_q.control};
    end
    if (access && hit && wb_we_i && wb_sel_i[0]) begin
      s_d.control = wb_dat_i[7:0] & `TPM_WRITE_MASK;
    end
    s_d.digital_sync_mid = digital_signals_i;
    s_d.digital_sync = s_q.digital_sync_mid;
    // Mode follows the freshly written value so the pin moves in the same cycle as ack
    if (s_d.control[`TPM_DIGITAL_EN_BIT]) begin
      s_d.mode = tpm_pkg::TPM_PIN_DIGITAL;
    end else if (s_d.control[`TPM_ANALOG_EN_BIT]) begin
      s_d.mode = tpm_pkg::TPM_PIN_ANALOG;
    end else begin
      s_d.mode = tpm_pkg::TPM_PIN_NORMAL;
    end
    s_d.probe_level = 1'b0;
    s_d.probe_oe = 1'b0;
    s_d.analog_connect = 1'b0;
    case (s_d.mode)
      tpm_pkg::TPM_PIN_DIGITAL: begin
        s_d.probe_oe = 1'b1;
        s_d.probe_level = digital_pick(s_d.control[`TPM_SELECT_MSB:`TPM_SELECT_LSB], s_q.digital_sync);
      end
      tpm_pkg::TPM_PIN_ANALOG: begin
        s_d.analog_connect = 1'b1;
      end
      tpm_pkg::TPM_PIN_NORMAL: begin
        s_d.probe_oe = 1'b0;
      end
      default: begin
        s_d.probe_oe = 1'b0;
      end
    endcase
    s_d.analog_channel = analog_channel_select_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.control <= `TPM_CONTROL_RESET;
      s_q.mode <= tpm_pkg::TPM_PIN_NORMAL;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o = s_q.rdata;
  assign wb_ack_o = s_q.ack;
  assign probe_pin_o = s_q.probe_level;
  assign probe_pin_oe_o = s_q.probe_oe;
  assign analog_connect_o = s_q.analog_connect;
  assign analog_channel_o = s_q.analog_channel;
  assign test_probe_control_o = s_q.control;

endmodule // tpm_test_probe_mux

`default_nettype wire

// ==== tb/tpm_checker_assertions.sv ====
// Probe mux port checker; bound to the mux top module.
// Assumes it sees only the top module's ports, clocked by clk_i with rst_i active high.
`timescale 1ns/100ps
`default_nettype none
module tpm_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic probe_pin_oe_o,
  input wire logic analog_connect_o,
  input wire logic [7:0] test_probe_control_o
);
  wire logic [1:0] en = test_probe_control_o[7:6];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
  a_ctrl_on_ack: assert property (!$stable(test_probe_control_o) |-> wb_ack_o) else $error("stray");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("idle data");
  a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper");
  a_bit5_zero: assert property (!test_probe_control_o[5] && !wb_dat_o[5]) else $error("bit 5");
  a_digital_wins: assert property (en[0] |-> probe_pin_oe_o && !analog_connect_o) else $error("dig");
  a_analog_path: assert property (en == 2'h2 |-> analog_connect_o && !probe_pin_oe_o) else $error("ana");
  a_normal_pin: assert property (en == 2'h0 |-> !analog_connect_o && !probe_pin_oe_o) else $error("idle");
endmodule // tpm_checker
bind tpm_test_probe_mux tpm_checker tpm_checker_inst (.*);
`default_nettype wire

// ==== tb/tpm_probe_instrument.sv ====
// Bench probe on the probe pin; 0 port, 1 analog, 2 or 3 digital level.
`timescale 1ns/100ps
`default_nettype none
module tpm_probe_instrument (
  input wire logic pin_i,
  input wire logic oe_i,
  input wire logic an_i,
  output logic [1:0] seen_o
);
  // Analog view is only the connection; no analog level or buffer offset is modelled
  assign seen_o = oe_i ? {1'b1, pin_i} : {1'b0, an_i};
endmodule // tpm_probe_instrument
`default_nettype wire

// ==== tb/tpm_test_probe_mux_tb.sv ====
// Register and probe pin tests; classic Wishbone master on clk_i.
`timescale 1ns/100ps
`default_nettype none
module tpm_test_probe_mux_tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic probe_pin_o, probe_pin_oe_o, analog_connect_o;
  logic [7:0] wb_adr_i = '0, test_probe_control_o;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
  logic [4:0] analog_channel_select_i = 5'h15, analog_channel_o;
  logic [23:0] digital_signals_i = '0;
  logic [1:0] seen;
  int n_fail = 0, n_tests = 0, i;
  initial forever #20 clk_i = ~clk_i;
  tpm_test_probe_mux tpm_test_probe_mux_inst (.*);
  tpm_probe_instrument tpm_probe_instrument_inst (.pin_i(probe_pin_o), .oe_i(probe_pin_oe_o),
    .an_i(analog_connect_o), .seen_o(seen));
  task automatic end_sim;
    $display("%0d compares %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [38:0] got, exp);
    n_tests++;
    n_fail += (got !== exp);
    if (got !== exp) $display("wrong value at %0t %h %h", $time, got, exp);
  endtask
  // Source line expected for each select code, -1 where the code is unassigned
  function automatic int src(input logic [4:0] c);
    if (c <= 5'h0D) return int'(c);
    if (c == 5'h0F || c == 5'h17) return 14;
    if (c == 5'h10 || c == 5'h11) return int'(c) - 1;
    if (c >= 5'h12 && c <= 5'h15) return int'(c) - 8;
    return -1;
  endfunction
  task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s, input logic [7:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, s, 24'h0, d};
    for (i = 0; i == 0 || (wb_ack_o !== 1'b1 && i < 9); i++) @(posedge clk_i);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    n_fail += (wb_ack_o !== 1'b1);
    if (wb_ack_o !== 1'b1) end_sim();
    @(negedge clk_i);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(8'h00, 0, 4'hF, 8'h00);
    chk({rd, seen}, '0);
    wb(8'h00, 1, 4'hF, 8'hBF);
    chk(seen, 2'h1);
    chk(test_probe_control_o, 8'h9F);
    wb(8'h04, 1, 4'hF, 8'h00);
    wb(8'h00, 1, 4'hE, 8'h00);
    wb(8'h00, 0, 4'hF, 8'h00);
    chk({rd, analog_channel_o, seen}, {32'h9F, 5'h15, 2'h1});
    $display("register test done");
    for (int k = 0; k < 64; k++) begin
      @(posedge clk_i);
      digital_signals_i <= {24{k[5]}};
      wb(8'h00, 1, 4'hF, {3'h6, k[4:0]});
      repeat (3) @(negedge clk_i);
      chk(seen, {1'b1, k[5] && !(k[4:0] inside {5'h0E, 5'h16}) && k[4:0] < 5'h18});
    end
    $display("mux test done");
    for (int k = 0; k < 32; k++) begin
      @(posedge clk_i);
      digital_signals_i <= (src(k[4:0]) >= 0) ? (24'h00_0001 << src(k[4:0])) : 24'hFF_FFFF;
      wb(8'h00, 1, 4'hF, {3'h2, k[4:0]});
      repeat (3) @(negedge clk_i);
      chk(seen, {1'b1, src(k[4:0]) >= 0});
    end
    @(posedge clk_i);
    digital_signals_i <= 24'h02_0000;
    wb(8'h00, 1, 4'hF, 8'h57);
    repeat (3) @(negedge clk_i);
    chk(seen, 2'h3);
    $display("source map test done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({test_probe_control_o, seen}, '0);
    $display("reset test done");
    wb(8'h00, 1, 4'hF, 8'hC0);
    wb(8'h00, 1, 4'hF, 8'h00);
    chk(seen, '0);
    $display("release test done");
    end_sim();
  end
endmodule // tpm_test_probe_mux_tb
`default_nettype wire
